// file: core/igs_regs.svh
`ifndef IGS_REGS_SVH
`define IGS_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses.
// ----------------------------------------------------------------------
`define IGS_ADDR_CFG   8'h00
`define IGS_ADDR_CORE  8'h04
`define IGS_ADDR_BP    8'h08
`define IGS_ADDR_NSAC  8'h0c
`define IGS_ADDR_STAT  8'h10

// ----------------------------------------------------------------------
// System configuration register fields.
// ----------------------------------------------------------------------
`define IGS_CFG_W      7
`define IGS_CFG_SD     0
`define IGS_CFG_SSEC   1
`define IGS_CFG_MON    2
`define IGS_CFG_HYP    3
`define IGS_CFG_M32    4
`define IGS_CFG_SYSREG 5
`define IGS_CFG_PESEC  6
`define IGS_CFG_RST    7'h00

// ----------------------------------------------------------------------
// Core routing register fields.
// ----------------------------------------------------------------------
`define IGS_CORE_W     7
`define IGS_CORE_RFIQ  0
`define IGS_CORE_RIRQ  1
`define IGS_CORE_NS    2
`define IGS_CORE_HFIQ  3
`define IGS_CORE_HIRQ  4
`define IGS_CORE_EL    5
`define IGS_CORE_RST   7'h00
`define IGS_EL1        2'h1
`define IGS_EL_HYP     2'h2
`define IGS_EL_MON     2'h3

// ----------------------------------------------------------------------
// Binary point register fields.
// ----------------------------------------------------------------------
`define IGS_BP_REG_W   15
`define IGS_BP_W       3
`define IGS_BP_G0      0
`define IGS_BP_G1S     4
`define IGS_BP_G1NS    8
`define IGS_BP_COMMON  12
`define IGS_BP_CNS     13
`define IGS_BP_CS      14
`define IGS_BP_RST     15'h0000

// ----------------------------------------------------------------------
// Generation permission register fields.
// ----------------------------------------------------------------------
`define IGS_NSAC_W     2
`define IGS_NSAC_G0    0
`define IGS_NSAC_G1S   1
`define IGS_NSAC_RST   2'h0

`endif

// file: core/igs_pkg.sv
package igs_pkg;

  // Interrupt group codes; in single-state mode group 1 uses IGS_GRP1NS.
  typedef enum logic [1:0] {
    IGS_GRP0   = 2'h0,
    IGS_GRP1S  = 2'h1,
    IGS_GRP1NS = 2'h2
  } igs_grp_t;

  // Kinds of interrupt handling access that carry a security check.
  typedef enum logic [1:0] {
    IGS_ACC_CFG   = 2'h0,
    IGS_ACC_ACK   = 2'h1,
    IGS_ACC_DROP  = 2'h2,
    IGS_ACC_DEACT = 2'h3
  } igs_acc_t;

  // The three software interrupt request registers.
  typedef enum logic [1:0] {
    IGS_SGI0  = 2'h0,
    IGS_SGI1  = 2'h1,
    IGS_ASGI1 = 2'h2
  } igs_sgi_t;

  // Complete state of the top module.
  typedef struct packed {
    logic [6:0]  cfg;
    logic [6:0]  core;
    logic [14:0] bp;
    logic [1:0]  nsac;
    logic        fiq;
    logic        irq;
    logic        grant;
    logic        deny;
    logic        virt;
    logic        sgi_gen;
    logic        sgi_block;
    logic        sgi_trap;
    igs_grp_t    sgi_grp;
    logic [31:0] rdata;
  } igs_state_t;

endpackage

// file: core/igs_sel_if.sv
`timescale 1ns/1ps
`default_nettype none

interface igs_sel_if;
  import igs_pkg::*;

  logic     two;
  logic     at_mon;
  logic     mon32;
  logic     core_secure;
  logic     hp_ok;
  igs_grp_t grp;
  logic     fiq_sel;
  logic     irq_sel;

  modport ctl (output two, at_mon, mon32, core_secure, hp_ok, grp,
               input fiq_sel, irq_sel);
  modport sel (input two, at_mon, mon32, core_secure, hp_ok, grp,
               output fiq_sel, irq_sel);
endinterface

`default_nettype wire

// file: core/igs_line_sel.sv
`timescale 1ns/1ps
`default_nettype none

module igs_line_sel (
  igs_sel_if.sel sel_if
);
  import igs_pkg::*;

  logic other_state;

  // --------------------------------------------------------------------
  // Line choice for the selected interrupt.
  // --------------------------------------------------------------------
  // A group 1 interrupt of the state the core is not in goes to the fast
  // line; with one state there is no other state to compare against.
  always_comb
  begin
    other_state = sel_if.two &
                  ((sel_if.grp == IGS_GRP1S) != sel_if.core_secure);
    sel_if.fiq_sel = 1'b0;
    sel_if.irq_sel = 1'b0;
    if (sel_if.hp_ok)
    begin
      if (sel_if.grp == IGS_GRP0)
        sel_if.fiq_sel = 1'b1; // R7
      else if (other_state | (sel_if.at_mon & ~sel_if.mon32))
        sel_if.fiq_sel = 1'b1; // R8
      else
        sel_if.irq_sel = 1'b1; // R9 R10
    end
  end

endmodule

`default_nettype wire

// file: core/igs_group_sec.sv
// Summary of operation
// R1: Security disable clear gives two states and three interrupt groups.
// R2: Security disable set gives one state and two groups only.
// R3: Two states: check accessor state on configure, acknowledge, drop, deactivate.
// R4: One state: those four accesses are never security checked.
// R5: Two states: software interrupt needs requester state and access control.
// R6: One state: software interrupts ignore the access control settings.
// R7: Group 0 selected interrupt drives the fast line unless R17 masks it.
// R8: Group 1 is fast if other state or at monitor not in 32-bit state, else normal.
// R9: Monitor in 32-bit state: secure group 1 normal, non-secure fast.
// R10: One state without monitor: group 0 fast, group 1 normal always.
// R11: Separate binary points per group; common flag shares the group 0 one.
// R12: Two monitor flags pick common binary point per group 1 state.
// R13: Core routes fast and normal lines by its routing and override bits.
// R14: Routing controls decide which level reaches interface registers.
// R15: Non-secure level 1 with an override bit set makes virtual accesses.
// R16: Virtual software interrupt requests trap to hypervisor level instead.
// R17: Two states, no monitor, non-secure core: only non-secure group 1 is signalled.
// R18: No monitor or hypervisor, secure core: non-secure group 1 masked.
// R19: One state without monitor: non-secure, routing cleared, interface on.
// R20: Software never targets groups a core's fixed state cannot take.
// R21: Two states: locality-specific interrupts are non-secure group 1.
// R22: Fast and normal lines are registered levels held while selected.
`timescale 1ns/1ps
`default_nettype none
`include "igs_regs.svh"

module igs_group_sec #(
  parameter int ADDR_W = 8
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [31:0]      reg_rdata_out,
  input  wire logic             hp_valid_in,
  input  wire logic             hp_prio_ok_in,
  input  wire logic             hp_lpi_in,
  input  wire igs_pkg::igs_grp_t hp_grp_in,
  output logic                  fiq_out,
  output logic                  irq_out,
  input  wire logic             acc_req_in,
  input  wire igs_pkg::igs_acc_t acc_kind_in,
  input  wire igs_pkg::igs_grp_t acc_grp_in,
  input  wire logic             acc_secure_in,
  output logic                  acc_grant_out,
  output logic                  acc_deny_out,
  output logic                  acc_virtual_out,
  input  wire logic             sgi_req_in,
  input  wire igs_pkg::igs_sgi_t sgi_reg_in,
  input  wire logic             sgi_secure_in,
  output logic                  sgi_gen_out,
  output logic                  sgi_block_out,
  output logic                  sgi_trap_out,
  output igs_pkg::igs_grp_t     sgi_grp_out
);
  import igs_pkg::*;

  // --------------------------------------------------------------------
  // Elaboration check.
  // --------------------------------------------------------------------
  // The decode looks at a full byte of address, so narrower buses cannot
  // be served; wider ones must keep their upper bits zero.
  generate
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_bad_addr
      $error("ADDR_W must lie between 8 and 32");
    end
  endgenerate

  // --------------------------------------------------------------------
  // Helper functions.
  // --------------------------------------------------------------------
  // Binary point used by a group 1 state: its own, or group 0's if shared.
  function automatic logic [2:0] bp_pick(input logic       share,
                                         input logic [2:0] own,
                                         input logic [2:0] grp0);
    bp_pick = share ? grp0 : own;
  endfunction

  // Exception level at which a line's interface registers are reachable.
  function automatic logic [1:0] reach_level(input logic to_mon,
                                             input logic ns,
                                             input logic ovr);
    if (to_mon)
      reach_level = `IGS_EL_MON;
    else if (ns & ovr)
      reach_level = `IGS_EL_HYP;
    else
      reach_level = `IGS_EL1;
  endfunction

  igs_state_t st_ff;
  igs_state_t nxt_st;
  igs_sel_if  sel_bus ();

  logic       two;
  logic       ns_only;
  logic       s_only;
  logic       single_nomon;
  logic       eff_ns;
  logic       eff_rfiq;
  logic       eff_rirq;
  logic       eff_sysreg;
  logic       at_mon;
  logic       core_secure;
  logic       virt_cond;
  logic [1:0] el;
  igs_grp_t   hp_grp;
  logic       grp_masked;
  logic [2:0] bp_g0;
  logic [2:0] bp_s;
  logic [2:0] bp_ns;
  igs_grp_t   sgi_grp;
  logic       sgi_ok;
  logic       acc_ok;
  logic       addr_hit;
  logic [31:0] stat_word;

  // --------------------------------------------------------------------
  // Effective security controls.
  // --------------------------------------------------------------------
  // Cores lacking a monitor level behave as if fixed values were programmed,
  // except secure two-state cores with a hypervisor level; the written bits are kept but overridden here.
  always_comb
  begin
    el           = st_ff.core[`IGS_CORE_EL +: 2];
    two          = ~st_ff.cfg[`IGS_CFG_SD]; // R1 R2
    ns_only      = two & ~st_ff.cfg[`IGS_CFG_MON] &
                   ~st_ff.cfg[`IGS_CFG_PESEC]; // R17
    s_only       = two & ~st_ff.cfg[`IGS_CFG_MON] &
                   ~st_ff.cfg[`IGS_CFG_HYP] &
                   st_ff.cfg[`IGS_CFG_PESEC]; // R18
    single_nomon = ~two & ~st_ff.cfg[`IGS_CFG_MON]; // R19
    eff_ns       = (ns_only | single_nomon) ? 1'b1 :
                   s_only ? 1'b0 : st_ff.core[`IGS_CORE_NS];
    eff_rfiq     = ns_only ? 1'b1 :
                   (s_only | single_nomon) ? 1'b0 :
                   st_ff.core[`IGS_CORE_RFIQ];
    eff_rirq     = (ns_only | s_only | single_nomon) ? 1'b0 :
                   st_ff.core[`IGS_CORE_RIRQ];
    eff_sysreg   = single_nomon | st_ff.cfg[`IGS_CFG_SYSREG]; // R19
    at_mon       = st_ff.cfg[`IGS_CFG_MON] & (el == `IGS_EL_MON);
    core_secure  = at_mon | ~eff_ns;
    virt_cond    = (el == `IGS_EL1) & eff_ns &
                   (st_ff.core[`IGS_CORE_HFIQ] |
                    st_ff.core[`IGS_CORE_HIRQ]); // R15
  end

  // --------------------------------------------------------------------
  // Selected interrupt qualification.
  // --------------------------------------------------------------------
  // Locality-specific interrupts carry no group of their own.
  always_comb
  begin
    hp_grp = (hp_lpi_in & two) ? IGS_GRP1NS : hp_grp_in; // R21
    case (hp_grp)
      IGS_GRP0:   grp_masked = ns_only; // R17
      IGS_GRP1S:  grp_masked = ns_only & two; // R17
      IGS_GRP1NS: grp_masked = s_only; // R18
      default:    grp_masked = 1'b1;
    endcase
  end

  assign sel_bus.two         = two;
  assign sel_bus.at_mon      = at_mon;
  assign sel_bus.mon32       = st_ff.cfg[`IGS_CFG_M32];
  assign sel_bus.core_secure = core_secure;
  assign sel_bus.hp_ok       = hp_valid_in & hp_prio_ok_in & ~grp_masked;
  assign sel_bus.grp         = hp_grp;

  igs_line_sel u_line_sel (
    .sel_if (sel_bus.sel)
  );

  // --------------------------------------------------------------------
  // Binary point sharing.
  // --------------------------------------------------------------------
  // The general common flag applies to the state the core is in; the two
  // monitor flags force sharing for one group 1 state regardless.
  always_comb
  begin
    bp_g0 = st_ff.bp[`IGS_BP_G0 +: `IGS_BP_W];
    bp_s  = bp_pick(st_ff.bp[`IGS_BP_CS] |
                    (st_ff.bp[`IGS_BP_COMMON] & core_secure),
                    st_ff.bp[`IGS_BP_G1S +: `IGS_BP_W], bp_g0); // R11 R12
    bp_ns = bp_pick(st_ff.bp[`IGS_BP_CNS] |
                    (st_ff.bp[`IGS_BP_COMMON] & ~core_secure),
                    st_ff.bp[`IGS_BP_G1NS +: `IGS_BP_W], bp_g0); // R11 R12
  end

  // --------------------------------------------------------------------
  // Security checks on accesses and software interrupts.
  // --------------------------------------------------------------------
  // Secure software may configure any group but handles only secure ones.
  always_comb
  begin
    if (!two)
      acc_ok = 1'b1; // R4
    else if (acc_kind_in == IGS_ACC_CFG)
      acc_ok = acc_secure_in | (acc_grp_in == IGS_GRP1NS); // R3
    else
      acc_ok = acc_secure_in == (acc_grp_in != IGS_GRP1NS); // R3
    case (sgi_reg_in)
      IGS_SGI0:  sgi_grp = IGS_GRP0;
      IGS_SGI1:  sgi_grp = (sgi_secure_in & two) ? IGS_GRP1S : IGS_GRP1NS;
      IGS_ASGI1: sgi_grp = (sgi_secure_in | ~two) ? IGS_GRP1NS : IGS_GRP1S;
      default:   sgi_grp = IGS_GRP0;
    endcase
    sgi_ok = ~two | sgi_secure_in | (sgi_grp == IGS_GRP1NS) |
             ((sgi_grp == IGS_GRP0) & st_ff.nsac[`IGS_NSAC_G0]) |
             ((sgi_grp == IGS_GRP1S) & st_ff.nsac[`IGS_NSAC_G1S]); // R5 R6
  end

  // --------------------------------------------------------------------
  // Status word.
  // --------------------------------------------------------------------
  always_comb
  begin
    stat_word        = 32'h0000_0000;
    stat_word[0]     = st_ff.fiq;
    stat_word[1]     = st_ff.irq;
    stat_word[3:2]   = two ? 2'h3 : 2'h2; // R1 R2
    stat_word[4]     = two; // R3 R4
    stat_word[7:5]   = bp_ns;
    stat_word[10:8]  = bp_s;
    stat_word[11]    = eff_ns;
    stat_word[12]    = eff_rfiq;
    stat_word[13]    = eff_rirq;
    stat_word[14]    = eff_sysreg;
    stat_word[15]    = virt_cond;
    stat_word[17:16] = reach_level(eff_rfiq, eff_ns,
                                   st_ff.core[`IGS_CORE_HFIQ]); // R14
    stat_word[19:18] = reach_level(eff_rirq, eff_ns,
                                   st_ff.core[`IGS_CORE_HIRQ]); // R14
    stat_word[20]    = ~two & st_ff.cfg[`IGS_CFG_SSEC]; // R2
  end

  // --------------------------------------------------------------------
  // Next state.
  // --------------------------------------------------------------------
  // Read data stand for exactly one cycle; unmapped reads return zero.
  // Addresses with upper bits set miss, so wide buses cannot alias.
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.rdata     = 32'h0000_0000;
    addr_hit         = (reg_addr_in >> 8) == '0;
    if (reg_wr_in && addr_hit)
    begin
      case (reg_addr_in[7:0])
        `IGS_ADDR_CFG:  nxt_st.cfg  = reg_wdata_in[`IGS_CFG_W-1:0];
        `IGS_ADDR_CORE: nxt_st.core = reg_wdata_in[`IGS_CORE_W-1:0];
        `IGS_ADDR_BP:   nxt_st.bp   = reg_wdata_in[`IGS_BP_REG_W-1:0];
        `IGS_ADDR_NSAC: nxt_st.nsac = reg_wdata_in[`IGS_NSAC_W-1:0];
        default:        nxt_st.nsac = st_ff.nsac;
      endcase
    end
    if (reg_rd_in && addr_hit)
    begin
      case (reg_addr_in[7:0])
        `IGS_ADDR_CFG:  nxt_st.rdata = {25'h0, st_ff.cfg};
        `IGS_ADDR_CORE: nxt_st.rdata = {25'h0, st_ff.core};
        `IGS_ADDR_BP:   nxt_st.rdata = {17'h0, st_ff.bp};
        `IGS_ADDR_NSAC: nxt_st.rdata = {30'h0, st_ff.nsac};
        `IGS_ADDR_STAT: nxt_st.rdata = stat_word;
        default:        nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // Line levels follow the selection each cycle and so drop by themselves.
    nxt_st.fiq       = sel_bus.fiq_sel; // R22
    nxt_st.irq       = sel_bus.irq_sel; // R22
    nxt_st.grant     = acc_req_in & acc_ok;
    nxt_st.deny      = acc_req_in & ~acc_ok;
    nxt_st.virt      = acc_req_in & virt_cond; // R15
    // A virtual request never creates an interrupt; it only traps.
    nxt_st.sgi_trap  = sgi_req_in & virt_cond; // R16
    nxt_st.sgi_gen   = sgi_req_in & ~virt_cond & sgi_ok; // R5 R6
    nxt_st.sgi_block = sgi_req_in & ~virt_cond & ~sgi_ok; // R5
    nxt_st.sgi_grp   = sgi_req_in ? sgi_grp : st_ff.sgi_grp;
  end

  // --------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      st_ff      <= '0;
      st_ff.cfg  <= `IGS_CFG_RST;
      st_ff.core <= `IGS_CORE_RST;
      st_ff.bp   <= `IGS_BP_RST;
      st_ff.nsac <= `IGS_NSAC_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign reg_rdata_out   = st_ff.rdata;
  assign fiq_out         = st_ff.fiq;
  assign irq_out         = st_ff.irq;
  assign acc_grant_out   = st_ff.grant;
  assign acc_deny_out    = st_ff.deny;
  assign acc_virtual_out = st_ff.virt;
  assign sgi_gen_out     = st_ff.sgi_gen;
  assign sgi_block_out   = st_ff.sgi_block;
  assign sgi_trap_out    = st_ff.sgi_trap;
  assign sgi_grp_out     = st_ff.sgi_grp;

  // --------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------
  group0_fast_a: assert property (@(posedge clk_in) // R7
    disable iff (!reset_n_in)
    (hp_valid_in && hp_prio_ok_in && hp_grp == IGS_GRP0 && !ns_only)
    |=> (fiq_out && !irq_out))
    else $error("group 0 interrupt not on fast line");

  other_state_a: assert property (@(posedge clk_in) // R8
    disable iff (!reset_n_in)
    (hp_valid_in && hp_prio_ok_in && two && !ns_only && !core_secure &&
     hp_grp == IGS_GRP1S) |=> fiq_out)
    else $error("other-state group 1 not on fast line");

  mon32_line_a: assert property (@(posedge clk_in) // R9
    disable iff (!reset_n_in)
    (hp_valid_in && hp_prio_ok_in && two && at_mon &&
     st_ff.cfg[`IGS_CFG_M32] && hp_grp == IGS_GRP1S) |=> irq_out)
    else $error("secure group 1 at 32-bit monitor not normal");

  single_line_a: assert property (@(posedge clk_in) // R10
    disable iff (!reset_n_in)
    (hp_valid_in && hp_prio_ok_in && single_nomon && hp_grp != IGS_GRP0)
    |=> (irq_out && !fiq_out))
    else $error("single state group 1 not on normal line");

  lpi_group_a: assert property (@(posedge clk_in) // R21
    disable iff (!reset_n_in)
    (hp_valid_in && hp_prio_ok_in && hp_lpi_in && two && eff_ns &&
     !at_mon && !s_only) |=> irq_out)
    else $error("locality interrupt not treated as non-secure group 1");

  line_drop_a: assert property (@(posedge clk_in) // R22
    disable iff (!reset_n_in)
    !hp_valid_in |=> (!fiq_out && !irq_out))
    else $error("line stayed up with nothing selected");

  acc_check_a: assert property (@(posedge clk_in) // R3
    disable iff (!reset_n_in)
    (acc_req_in && two && !acc_secure_in && acc_grp_in != IGS_GRP1NS)
    |=> (acc_deny_out && !acc_grant_out))
    else $error("non-secure access to secure group not denied");

  // A grant may only stand a second cycle for a back-to-back request.
  acc_free_a: assert property (@(posedge clk_in) // R4
    disable iff (!reset_n_in)
    (acc_req_in && !two) |=> (acc_grant_out && !acc_deny_out) ##1
    (!acc_grant_out || $past(acc_req_in)))
    else $error("single state access not granted for one cycle");

  sgi_perm_a: assert property (@(posedge clk_in) // R5
    disable iff (!reset_n_in)
    (sgi_req_in && two && !virt_cond && !sgi_secure_in &&
     sgi_reg_in == IGS_SGI0 && !st_ff.nsac[`IGS_NSAC_G0])
    |=> (sgi_block_out && !sgi_gen_out))
    else $error("unpermitted software interrupt generated");

  sgi_free_a: assert property (@(posedge clk_in) // R6
    disable iff (!reset_n_in)
    (sgi_req_in && !two && !virt_cond) |=> sgi_gen_out)
    else $error("single state software interrupt refused");

  virt_trap_a: assert property (@(posedge clk_in) // R16
    disable iff (!reset_n_in)
    (sgi_req_in && virt_cond) |=> (sgi_trap_out && !sgi_gen_out))
    else $error("virtual software interrupt request did not trap");

  virt_acc_a: assert property (@(posedge clk_in) // R15
    disable iff (!reset_n_in)
    (acc_req_in && el == `IGS_EL1 && eff_ns &&
     st_ff.core[`IGS_CORE_HFIQ]) |=> acc_virtual_out)
    else $error("override access not marked virtual");

endmodule

`default_nettype wire

// file: sim/igs_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module igs_core_model (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       fiq_in,
  output logic      [7:0] fiq_cnt_out
);
  logic prev_ff;

  // The core takes one exception per rising level, so a line that
  // chattered would show up here as extra exceptions. Where the routing
  // and override bits send the exception does not change the count.
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      prev_ff <= 1'b0;
      fiq_cnt_out <= 8'h00;
    end
    else
    begin
      prev_ff <= fiq_in;
      fiq_cnt_out <= fiq_cnt_out + {7'h00, fiq_in & ~prev_ff};
    end
  end
endmodule

`default_nettype wire

// file: sim/test_igs_group_sec.sv
`timescale 1ns/1ps
`default_nettype none
`include "igs_regs.svh"

module test_igs_group_sec;
  import igs_pkg::*;

  logic        clk_in, reset_n_in, wr, rd, hv, hok, hlpi, acq, asec, sq;
  logic        fiq, irq, gnt, dny, virt, sgen, sblk, strap;
  logic [7:0]  addr, fcnt;
  logic [31:0] wdata, rdata;
  igs_grp_t    hgrp, agrp, sgrp;
  igs_acc_t    akind;
  igs_sgi_t    sreg;
  int          miscompares, n_checks, n_fiq;

  igs_group_sec u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .hp_valid_in(hv), .hp_prio_ok_in(hok),
    .hp_lpi_in(hlpi), .hp_grp_in(hgrp), .fiq_out(fiq), .irq_out(irq),
    .acc_req_in(acq), .acc_kind_in(akind), .acc_grp_in(agrp),
    .acc_secure_in(asec), .acc_grant_out(gnt), .acc_deny_out(dny),
    .acc_virtual_out(virt), .sgi_req_in(sq), .sgi_reg_in(sreg),
    .sgi_secure_in(asec), .sgi_gen_out(sgen), .sgi_block_out(sblk),
    .sgi_trap_out(strap), .sgi_grp_out(sgrp)
  );

  igs_core_model u_core (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .fiq_in(fiq),
    .fiq_cnt_out(fcnt)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    check(rdata & m, e);
  endtask

  task automatic line(input igs_grp_t g, input logic l, f, i);
    @(posedge clk_in);
    hv <= 1'b1;
    hgrp <= g;
    hlpi <= l;
    @(posedge clk_in);
    #1;
    check({30'h0, fiq, irq}, {30'h0, f, i});
    n_fiq += int'(f);
    @(posedge clk_in);
    hv <= 1'b0;
    @(posedge clk_in);
    #1;
    check({30'h0, fiq, irq}, 32'h0);
  endtask

  // Access check and software request go out in the same cycle.
  task automatic req(input igs_acc_t k, input igs_grp_t g, input igs_sgi_t r,
                     input logic s, input logic [7:0] m, e);
    @(posedge clk_in);
    acq <= 1'b1;
    sq <= 1'b1;
    akind <= k;
    agrp <= g;
    sreg <= r;
    asec <= s;
    @(posedge clk_in);
    acq <= 1'b0;
    sq <= 1'b0;
    #1;
    check({24'h0, gnt, dny, virt, sgen, sblk, strap, sgrp} & m, {24'h0, e});
  endtask

  task automatic t_regs;
    rreg(`IGS_ADDR_CFG, 32'hffffffff, 32'h0);
    rreg(`IGS_ADDR_STAT, 32'h1c, 32'h1c);
    wreg(`IGS_ADDR_CFG, 32'h03);
    rreg(`IGS_ADDR_CFG, 32'hffffffff, 32'h03);
    rreg(`IGS_ADDR_STAT, 32'h10001c, 32'h100008);
    wreg(`IGS_ADDR_STAT, 32'hffffffff);
    rreg(`IGS_ADDR_STAT, 32'h10001c, 32'h100008);
    rreg(8'h14, 32'hffffffff, 32'h0);
    $display("test registers done");
  endtask

  task automatic t_mon;
    wreg(`IGS_ADDR_CFG, 32'h04);
    wreg(`IGS_ADDR_CORE, 32'h24);
    line(IGS_GRP0, 1'b0, 1'b1, 1'b0);
    line(IGS_GRP1NS, 1'b0, 1'b0, 1'b1);
    line(IGS_GRP1S, 1'b0, 1'b1, 1'b0);
    line(IGS_GRP0, 1'b1, 1'b0, 1'b1);
    hok <= 1'b0;
    line(IGS_GRP0, 1'b0, 1'b0, 1'b0);
    hok <= 1'b1;
    wreg(`IGS_ADDR_CORE, 32'h60);
    line(IGS_GRP1NS, 1'b0, 1'b1, 1'b0);
    line(IGS_GRP1S, 1'b0, 1'b1, 1'b0);
    wreg(`IGS_ADDR_CFG, 32'h14);
    line(IGS_GRP1S, 1'b0, 1'b0, 1'b1);
    line(IGS_GRP1NS, 1'b0, 1'b1, 1'b0);
    line(IGS_GRP0, 1'b0, 1'b1, 1'b0);
    $display("test lines with monitor done");
  endtask

  task automatic t_nomon;
    wreg(`IGS_ADDR_CFG, 32'h00);
    wreg(`IGS_ADDR_CORE, 32'h20);
    line(IGS_GRP0, 1'b0, 1'b0, 1'b0);
    line(IGS_GRP1S, 1'b0, 1'b0, 1'b0);
    line(IGS_GRP1NS, 1'b0, 1'b0, 1'b1);
    rreg(`IGS_ADDR_STAT, 32'h3800, 32'h1800);
    wreg(`IGS_ADDR_CFG, 32'h40);
    wreg(`IGS_ADDR_CORE, 32'h27);
    line(IGS_GRP1NS, 1'b0, 1'b0, 1'b0);
    line(IGS_GRP1S, 1'b0, 1'b0, 1'b1);
    rreg(`IGS_ADDR_STAT, 32'h3800, 32'h0);
    wreg(`IGS_ADDR_CFG, 32'h48);
    rreg(`IGS_ADDR_STAT, 32'h3800, 32'h3800);
    wreg(`IGS_ADDR_CFG, 32'h01);
    wreg(`IGS_ADDR_CORE, 32'h43);
    line(IGS_GRP0, 1'b0, 1'b1, 1'b0);
    line(IGS_GRP1NS, 1'b0, 1'b0, 1'b1);
    rreg(`IGS_ADDR_STAT, 32'h7800, 32'h4800);
    $display("test lines without monitor done");
  endtask

  task automatic t_acc;
    wreg(`IGS_ADDR_CFG, 32'h04);
    wreg(`IGS_ADDR_CORE, 32'h24);
    req(IGS_ACC_ACK, IGS_GRP0, IGS_SGI0, 1'b0, 8'hff, 8'h48);
    req(IGS_ACC_ACK, IGS_GRP0, IGS_SGI0, 1'b1, 8'hff, 8'h90);
    for (int k = 0; k < 4; k++)
    begin
      req(igs_acc_t'(k), IGS_GRP1S, IGS_SGI1, 1'b0, 8'hff, 8'h52);
      req(igs_acc_t'(k), IGS_GRP1NS, IGS_ASGI1, 1'b0, 8'hff, 8'h89);
    end
    wreg(`IGS_ADDR_NSAC, 32'h3);
    req(IGS_ACC_DROP, IGS_GRP0, IGS_SGI0, 1'b0, 8'hff, 8'h50);
    req(IGS_ACC_DEACT, IGS_GRP1NS, IGS_ASGI1, 1'b0, 8'hff, 8'h91);
    wreg(`IGS_ADDR_CORE, 32'h2c);
    rreg(`IGS_ADDR_STAT, 32'hf8000, 32'h68000);
    req(IGS_ACC_ACK, IGS_GRP1NS, IGS_SGI1, 1'b0, 8'h3c, 8'h24);
    wreg(`IGS_ADDR_CORE, 32'h34);
    req(IGS_ACC_CFG, IGS_GRP1NS, IGS_SGI0, 1'b0, 8'h3c, 8'h24);
    wreg(`IGS_ADDR_CFG, 32'h01);
    wreg(`IGS_ADDR_CORE, 32'h40);
    wreg(`IGS_ADDR_NSAC, 32'h0);
    for (int k = 0; k < 4; k++)
      req(igs_acc_t'(k), IGS_GRP1S, IGS_SGI1, 1'b0, 8'hff, 8'h92);
    req(IGS_ACC_ACK, IGS_GRP0, IGS_SGI0, 1'b0, 8'hff, 8'h90);
    $display("test access and generation done");
  endtask

  task automatic t_bp;
    wreg(`IGS_ADDR_CFG, 32'h04);
    wreg(`IGS_ADDR_CORE, 32'h24);
    wreg(`IGS_ADDR_BP, 32'h0235);
    rreg(`IGS_ADDR_STAT, 32'h7e0, 32'h340);
    wreg(`IGS_ADDR_BP, 32'h1235);
    rreg(`IGS_ADDR_STAT, 32'h7e0, 32'h3a0);
    wreg(`IGS_ADDR_BP, 32'h4235);
    rreg(`IGS_ADDR_STAT, 32'h7e0, 32'h540);
    wreg(`IGS_ADDR_BP, 32'h2235);
    rreg(`IGS_ADDR_STAT, 32'h7e0, 32'h3a0);
    wreg(`IGS_ADDR_CORE, 32'h60);
    wreg(`IGS_ADDR_BP, 32'h1235);
    rreg(`IGS_ADDR_STAT, 32'h7e0, 32'h540);
    $display("test binary point done");
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // The tests need well under a thousand cycles; this cuts a hang short.
  initial
  begin
    #20000;
    miscompares++;
    end_sim;
  end

  initial
  begin
    {wr, rd, hv, hok, hlpi, acq, asec, sq} = 8'h10;
    {addr, wdata} = 40'h0;
    {hgrp, agrp, akind, sreg} = 8'h0;
    reset_n_in = 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_regs;
    t_mon;
    t_nomon;
    t_acc;
    t_bp;
    check({24'h0, fcnt}, 32'(n_fiq));
    end_sim;
  end
endmodule

`default_nettype wire
